// file: hdl/twt_pkg.sv
// shared constants, types and helpers for the twin/flicker timer core
package twt_pkg;

  // clock and base tick timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_TICK_NS = 1_000_000;
  localparam int MS_TICK_CYC = MS_TICK_NS / CLK_PERIOD_NS;

  // input filter widths in milliseconds
  localparam int FILT_SLOW_MS = 20;
  localparam int FILT_FAST_MS = 1;

  // duty arithmetic
  localparam logic [6:0] DUTY_FULL = 7'h64;
  localparam logic [22:0] DUTY_ROUND = 23'h000032;
  localparam logic [22:0] DUTY_DIV = 23'h000064;

  // switch bank pin positions (pin n sits at bit n-1)
  localparam int SW_EN = 0;
  localparam int SW_OFF_LO = 1;
  localparam int SW_OFF_HI = 2;
  localparam int SW_ON_LO = 3;
  localparam int SW_ON_HI = 4;
  localparam int SW_START = 5;
  localparam int SW_DIR = 6;
  localparam int SW_FILT = 7;
  localparam logic [7:0] SW_FACTORY = 8'h00;

  // time ranges; first four match the switch pin pair codes
  typedef enum logic [2:0] {
    RNG_10MS,
    RNG_100MS,
    RNG_1S,
    RNG_MINSEC,
    RNG_1MS,
    RNG_HOURMIN
  } twt_range_t;

  // timer configuration word
  typedef struct packed {
    twt_range_t off_range;
    twt_range_t on_range;
    logic start_on;
    logic count_down;
    logic filt_fast;
  } twt_cfg_t;

  localparam twt_cfg_t CFG_RESET = '{RNG_10MS, RNG_10MS, 1'b0, 1'b0, 1'b0};

  // self-diagnostic fault kinds
  typedef enum logic [1:0] {FLT_NONE, FLT_CPU, FLT_RAM, FLT_NVM} twt_fault_t;

  // display selections
  typedef enum logic [1:0] {
    MAIN_PV,
    MAIN_PROCESSOR_FAULT_CODE,
    MAIN_MEMORY_FAULT_CODE
  } twt_main_t;

  typedef enum logic [1:0] {SUB_SET, SUB_CYCLE, SUB_DARK, SUB_SUM} twt_sub_t;

  // display word
  typedef struct packed {
    twt_main_t main_sel;
    twt_sub_t sub_sel;
    logic cycle_indicator;
    logic [15:0] pv;
  } twt_disp_t;

  // milliseconds per count unit of a range
  function automatic logic [16:0] unit_ms(input twt_range_t rng);
    case (rng)
      RNG_1MS: unit_ms = 17'h00001;
      RNG_10MS: unit_ms = 17'h0000A;
      RNG_100MS: unit_ms = 17'h00064;
      RNG_1S: unit_ms = 17'h003E8;
      RNG_MINSEC: unit_ms = 17'h003E8;
      RNG_HOURMIN: unit_ms = 17'h0EA60;
      default: unit_ms = 17'h00001;
    endcase
  endfunction : unit_ms

endpackage : twt_pkg

// file: hdl/twt_in_filter.sv
// synchroniser and debounce filter for one external input
`timescale 1ns/10ps
module twt_in_filter
  import twt_pkg::*;
#(
  parameter int CNT_W = 5
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // pin and timing
  input wire logic pin_i,
  input wire logic ms_tick_i,
  input wire logic [CNT_W-1:0] width_ms_i,
  // filtered level
  output logic level_o
);

  logic s1_reg;
  logic s2_reg;
  logic lvl_reg;
  logic lvl_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;

  // accept a new level once it has stood for the width in ms
  always_comb begin
    lvl_next = lvl_reg;
    cnt_next = cnt_reg;
    if (s2_reg == lvl_reg) begin
      cnt_next = '0;
    end else if (ms_tick_i) begin
      if (cnt_reg + 1'b1 >= width_ms_i) begin
        lvl_next = s2_reg;
        cnt_next = '0;
      end else begin
        cnt_next = cnt_reg + 1'b1;
      end
    end
  end

  // registers, two-flop synchroniser first
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      lvl_reg <= 1'b0;
      cnt_reg <= '0;
    end else begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      lvl_reg <= lvl_next;
      cnt_reg <= cnt_next;
    end
  end

  assign level_o = lvl_reg;

endmodule : twt_in_filter

// file: hdl/twt_timer_core.sv
// twin timer and duty flicker output core with self-diagnostic handling
//
// Behaviour
// RULE_01 - flicker on time is cycle times duty over 100, rounded to range unit
// RULE_02 - hundredth-second range keeps on time to 0.01 s
// RULE_03 - while editing flicker, sub shows cycle time and cycle indicator lights
// RULE_04 - duty set value accepted from 0 to 100 percent
// RULE_05 - cycle time zero holds output off whatever the duty
// RULE_06 - nonzero cycle with duty zero holds output off
// RULE_07 - duty 100 holds output continuously on
// RULE_08 - processor fault: its code, dark sub, output off; reset key clears
// RULE_09 - working memory fault: memory code, dark sub, off; power only clears
// RULE_10 - nonvolatile fault: memory code, sum sub, off; reset key restores factory
// RULE_11 - switch bank used only when pin 1 is on
// RULE_12 - pins 2 and 3 choose the off interval range
// RULE_13 - pins 4 and 5 choose the on interval range
// RULE_14 - pin 6 start phase, pin 7 count direction, pin 8 filter width
// RULE_15 - factory default treats every switch pin as off
// RULE_16 - switch bank sampled once at power-up only
// RULE_17 - ranges outside the switch set come from the front keys
// RULE_18 - keys allow off ranges up to 9999 hours; the code counts at most 65535 one-minute units (about 1092 hours)
// RULE_19 - keys allow on ranges from 1 ms to 9999 hours; the code counts at most 65535 one-minute units (about 1092 hours)
// RULE_20 - up count shows elapsed time, down count shows remaining
// RULE_21 - starts in single timer operation; twin only by mode change
// RULE_22 - twin operation alternates off and on intervals from start phase
`timescale 1ns/10ps
module twt_timer_core
  import twt_pkg::*;
#(
  parameter int MS_TICK_CYCLES = MS_TICK_CYC,
  parameter int VAL_W = 16
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic arst_n_i,
  // switch bank and external pins
  input wire logic [7:0] switch_i,
  input wire logic reset_in_i,
  input wire logic gate_in_i,
  input wire logic reset_key_i,
  // key-entered configuration and mode
  input wire twt_cfg_t key_cfg_i,
  input wire logic twin_mode_i,
  input wire logic flicker_mode_i,
  input wire logic edit_cycle_i,
  // set values
  input wire logic [VAL_W-1:0] cycle_time_i,
  input wire twt_range_t cycle_range_i,
  input wire logic [6:0] duty_i,
  input wire logic [VAL_W-1:0] off_time_i,
  input wire logic [VAL_W-1:0] on_time_i,
  // self-diagnostic reports
  input wire logic cpu_fault_i,
  input wire logic ram_fault_i,
  input wire logic nvm_fault_i,
  // outputs
  output logic out_o,
  output twt_disp_t disp_o,
  output twt_cfg_t cfg_o,
  output twt_fault_t fault_o,
  output logic factory_restore_o
);

  typedef enum logic [1:0] {PH_IDLE, PH_OFF, PH_ON} twt_phase_t;

  localparam int FW = 5;
  localparam logic [FW-1:0] FILT_SLOW = FW'(FILT_SLOW_MS);
  localparam logic [FW-1:0] FILT_FAST = FW'(FILT_FAST_MS);
  localparam logic [16:0] TICK_LAST = 17'(MS_TICK_CYCLES - 1);

  // state
  logic [16:0] tick_cnt_reg, tick_cnt_next;
  logic ms_tick_reg, ms_tick_next;
  logic [7:0] sw_s1_reg, sw_s2_reg;
  logic [1:0] boot_cnt_reg, boot_cnt_next;
  logic cfg_taken_reg, cfg_taken_next;
  twt_cfg_t cfg_reg, cfg_next;
  twt_fault_t fault_reg, fault_next;
  logic key_prev_reg, key_prev_next;
  logic restore_reg, restore_next;
  twt_phase_t phase_reg, phase_next;
  logic [16:0] ms_cnt_reg, ms_cnt_next;
  logic [VAL_W-1:0] cnt_reg, cnt_next;
  logic out_reg, out_next;
  twt_disp_t disp_reg, disp_next;

  // derived
  logic [2:0] filt_lvl;
  logic rst_f, gate_f, key_f, key_press;
  logic [6:0] duty_c;
  logic [VAL_W-1:0] on_calc;
  logic [22:0] prod;
  logic forced_off, forced_on, run;
  logic [VAL_W-1:0] cur_len;
  twt_range_t cur_range;
  logic unit_tick, phase_end;

  // 1 ms enable from the core clock
  always_comb begin
    tick_cnt_next = tick_cnt_reg + 17'h00001;
    ms_tick_next = 1'b0;
    if (tick_cnt_reg >= TICK_LAST) begin
      tick_cnt_next = '0;
      ms_tick_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      tick_cnt_reg <= '0;
      ms_tick_reg <= 1'b0;
    end else begin
      tick_cnt_reg <= tick_cnt_next;
      ms_tick_reg <= ms_tick_next;
    end
  end

  // filters for reset input, gate input and reset key
  generate
    for (genvar g = 0; g < 3; g++) begin : g_filt
      twt_in_filter #(.CNT_W(FW)) u_filt (
        .core_clk_i(core_clk_i),
        .arst_n_i(arst_n_i),
        .pin_i(g == 0 ? reset_in_i : (g == 1 ? gate_in_i : reset_key_i)),
        .ms_tick_i(ms_tick_reg),
        .width_ms_i(cfg_reg.filt_fast ? FILT_FAST : FILT_SLOW), // see RULE_14
        .level_o(filt_lvl[g])
      );
    end
  endgenerate

  assign rst_f = filt_lvl[0];
  assign gate_f = filt_lvl[1];
  assign key_f = filt_lvl[2];
  assign key_press = key_f && !key_prev_reg;

  // power-up sampling of the switch bank
  always_comb begin
    boot_cnt_next = boot_cnt_reg;
    cfg_taken_next = cfg_taken_reg;
    cfg_next = cfg_reg;
    if (boot_cnt_reg != 2'h3) begin
      boot_cnt_next = boot_cnt_reg + 2'h1;
    end
    if (boot_cnt_reg == 2'h2 && !cfg_taken_reg) begin // see RULE_16
      cfg_taken_next = 1'b1;
      if (sw_s2_reg[SW_EN]) begin // see RULE_11
        cfg_next.off_range = twt_range_t'({1'b0, sw_s2_reg[SW_OFF_HI],
                                           sw_s2_reg[SW_OFF_LO]}); // see RULE_12
        cfg_next.on_range = twt_range_t'({1'b0, sw_s2_reg[SW_ON_HI],
                                          sw_s2_reg[SW_ON_LO]}); // see RULE_13
        cfg_next.start_on = sw_s2_reg[SW_START]; // see RULE_14
        cfg_next.count_down = sw_s2_reg[SW_DIR];
        cfg_next.filt_fast = sw_s2_reg[SW_FILT];
      end else begin
        cfg_next = key_cfg_i; // see RULE_17
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sw_s1_reg <= SW_FACTORY; // see RULE_15
      sw_s2_reg <= SW_FACTORY;
      boot_cnt_reg <= 2'h0;
      cfg_taken_reg <= 1'b0;
      cfg_reg <= CFG_RESET;
    end else begin
      sw_s1_reg <= switch_i;
      sw_s2_reg <= sw_s1_reg;
      boot_cnt_reg <= boot_cnt_next;
      cfg_taken_reg <= cfg_taken_next;
      cfg_reg <= cfg_next;
    end
  end

  // fault latch; a new report wins over a clear in the same cycle, except that a nonvolatile clear drops a processor or working memory report
  always_comb begin
    fault_next = fault_reg;
    restore_next = 1'b0;
    key_prev_next = key_f;
    case (fault_reg)
      FLT_NONE: begin
        if (nvm_fault_i) begin
          fault_next = FLT_NVM;
        end else if (ram_fault_i) begin
          fault_next = FLT_RAM;
        end else if (cpu_fault_i) begin
          fault_next = FLT_CPU;
        end
      end
      FLT_CPU: begin
        if (nvm_fault_i) begin
          fault_next = FLT_NVM;
        end else if (ram_fault_i) begin
          fault_next = FLT_RAM;
        end else if (key_press && !cpu_fault_i) begin
          fault_next = FLT_NONE; // see RULE_08
        end
      end
      FLT_RAM: fault_next = FLT_RAM; // see RULE_09
      FLT_NVM: begin
        if (key_press && !nvm_fault_i) begin
          fault_next = FLT_NONE; // see RULE_10
          restore_next = 1'b1;
        end
      end
      default: fault_next = FLT_NONE;
    endcase
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fault_reg <= FLT_NONE;
      restore_reg <= 1'b0;
      key_prev_reg <= 1'b0;
    end else begin
      fault_reg <= fault_next;
      restore_reg <= restore_next;
      key_prev_reg <= key_prev_next;
    end
  end

  // duty arithmetic, rounded to the cycle range unit
  assign duty_c = (duty_i > DUTY_FULL) ? DUTY_FULL : duty_i; // see RULE_04
  assign prod = 23'(cycle_time_i) * 23'(duty_c);
  assign on_calc = VAL_W'((prod + DUTY_ROUND) / DUTY_DIV); // see RULE_01, RULE_02
  assign forced_off = flicker_mode_i && !twin_mode_i &&
                      (cycle_time_i == '0 || duty_c == 7'h00); // see RULE_05
  assign forced_on = flicker_mode_i && !twin_mode_i &&
                     cycle_time_i != '0 && duty_c == DUTY_FULL; // see RULE_07
  assign run = cfg_taken_reg && fault_reg == FLT_NONE && !rst_f &&
               (twin_mode_i || flicker_mode_i) && !forced_off && !forced_on;

  // current interval length and its unit
  always_comb begin
    if (twin_mode_i) begin // see RULE_18, RULE_19
      cur_range = (phase_reg == PH_ON) ? cfg_reg.on_range : cfg_reg.off_range;
      cur_len = (phase_reg == PH_ON) ? on_time_i : off_time_i;
    end else begin
      cur_range = cycle_range_i;
      cur_len = (phase_reg == PH_ON) ? on_calc : cycle_time_i - on_calc;
    end
  end

  assign unit_tick = ms_tick_reg && !gate_f &&
                     (ms_cnt_reg + 17'h00001 >= unit_ms(cur_range));
  assign phase_end = (cur_len == '0) ||
                     (unit_tick && cnt_reg + 1'b1 >= cur_len);

  // interval sequencer
  always_comb begin
    phase_next = phase_reg;
    ms_cnt_next = ms_cnt_reg;
    cnt_next = cnt_reg;
    if (!run) begin
      phase_next = PH_IDLE;
      ms_cnt_next = '0;
      cnt_next = '0;
    end else begin
      case (phase_reg)
        PH_IDLE: begin
          phase_next = (!twin_mode_i || cfg_reg.start_on) ?
                       PH_ON : PH_OFF; // see RULE_22
        end
        PH_OFF, PH_ON: begin
          if (phase_end) begin
            phase_next = (phase_reg == PH_ON) ? PH_OFF : PH_ON; // see RULE_22
            ms_cnt_next = '0;
            cnt_next = '0;
          end else if (ms_tick_reg && !gate_f) begin
            if (unit_tick) begin
              ms_cnt_next = '0;
              cnt_next = cnt_reg + 1'b1;
            end else begin
              ms_cnt_next = ms_cnt_reg + 17'h00001;
            end
          end
        end
        default: phase_next = PH_IDLE;
      endcase
    end
  end

  // output level and display selection
  always_comb begin
    out_next = 1'b0;
    disp_next = '{MAIN_PV, SUB_SET, 1'b0, '0};
    disp_next.pv = cfg_reg.count_down ? cur_len - cnt_reg : cnt_reg; // see RULE_20
    case (fault_reg)
      FLT_CPU: begin
        disp_next.main_sel = MAIN_PROCESSOR_FAULT_CODE; // see RULE_08
        disp_next.sub_sel = SUB_DARK;
      end
      FLT_RAM: begin
        disp_next.main_sel = MAIN_MEMORY_FAULT_CODE; // see RULE_09
        disp_next.sub_sel = SUB_DARK;
      end
      FLT_NVM: begin
        disp_next.main_sel = MAIN_MEMORY_FAULT_CODE; // see RULE_10
        disp_next.sub_sel = SUB_SUM;
      end
      default: begin
        if (forced_on && cfg_taken_reg && !rst_f) begin
          out_next = 1'b1; // see RULE_07
        end else begin
          out_next = run && phase_reg == PH_ON; // see RULE_06, RULE_21
        end
        if (edit_cycle_i && flicker_mode_i && !twin_mode_i) begin
          disp_next.sub_sel = SUB_CYCLE; // see RULE_03
          disp_next.cycle_indicator = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase_reg <= PH_IDLE;
      ms_cnt_reg <= '0;
      cnt_reg <= '0;
      out_reg <= 1'b0;
      disp_reg <= '{MAIN_PV, SUB_SET, 1'b0, '0};
    end else begin
      phase_reg <= phase_next;
      ms_cnt_reg <= ms_cnt_next;
      cnt_reg <= cnt_next;
      out_reg <= out_next;
      disp_reg <= disp_next;
    end
  end

  assign out_o = out_reg;
  assign disp_o = disp_reg;
  assign cfg_o = cfg_reg;
  assign fault_o = fault_reg;
  assign factory_restore_o = restore_reg;

  // checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_on_done;
    phase_reg == PH_ON && phase_end && run && twin_mode_i;
  endsequence

  a_cycle_zero_off: assert property ( // see RULE_05
    flicker_mode_i && !twin_mode_i && cycle_time_i == '0 |=> !out_o)
    else $error("output on with zero cycle time");
  a_duty_zero_off: assert property ( // see RULE_06
    flicker_mode_i && !twin_mode_i && duty_i == 7'h00 |=> !out_o)
    else $error("output on with zero duty");
  a_duty_full_on: assert property ( // see RULE_07
    forced_on && cfg_taken_reg && !rst_f && fault_reg == FLT_NONE
    |=> out_o)
    else $error("output off with full duty");
  a_fault_out_off: assert property ( // see RULE_08
    fault_reg != FLT_NONE |=> !out_o && disp_o.main_sel != MAIN_PV)
    else $error("output on during fault");
  a_ram_fault_hold: assert property ( // see RULE_09
    fault_o == FLT_RAM |=> fault_o == FLT_RAM && disp_o.sub_sel == SUB_DARK)
    else $error("working memory fault left");
  a_nvm_restore: assert property ( // see RULE_10
    fault_o == FLT_NVM && key_press && !nvm_fault_i
    |=> factory_restore_o && fault_o == FLT_NONE)
    else $error("factory restore missing");
  a_cfg_frozen: assert property ( // see RULE_16
    cfg_taken_reg |=> $stable(cfg_o))
    else $error("configuration changed after power-up");
  a_switch_off_keys: assert property ( // see RULE_11
    boot_cnt_reg == 2'h2 && !cfg_taken_reg && !sw_s2_reg[SW_EN]
    |=> cfg_o == $past(key_cfg_i))
    else $error("switch bank used while disabled");
  a_twin_alternate: assert property ( // see RULE_22
    s_on_done |=> phase_reg == PH_OFF ##1 !out_o)
    else $error("on interval not followed by off");
  a_single_idle: assert property ( // see RULE_21
    !twin_mode_i && !flicker_mode_i |=> ##1 !out_o)
    else $error("output on in single operation");

endmodule : twt_timer_core

// file: verification/twt_operator.sv
// operator side model: switch bank, front reset key, external inputs
`timescale 1ns/10ps
module twt_operator (
  // clock
  input wire logic core_clk_i,
  // commands from the bench
  input wire logic [7:0] switch_set_i,
  input wire logic press_i,
  // pins toward the timer
  output logic [7:0] switch_o,
  output logic reset_key_o,
  output logic reset_in_o,
  output logic gate_in_o,
  output logic busy_o
);
  int hold_cnt = 0;

  // switch levels are mechanical and only moved by the bench
  assign switch_o = switch_set_i;
  // external reset and gate inputs stay released
  assign reset_in_o = 1'b0;
  assign gate_in_o = 1'b0;

  // key held past the slow filter, then released just as long
  always @(posedge core_clk_i) begin
    if (press_i && hold_cnt == 0) begin
      hold_cnt <= 600;
    end else if (hold_cnt > 0) begin
      hold_cnt <= hold_cnt - 1;
    end
  end
  assign reset_key_o = hold_cnt > 300;
  assign busy_o = hold_cnt != 0;
endmodule : twt_operator

// file: verification/tb.sv
// self-checking bench for the twin/flicker timer core
`timescale 1ns/10ps
module tb;
  import twt_pkg::*;
  localparam int TK = 10; // clock cycles per 1 ms tick in simulation
  logic core_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] sw_set = 8'h00;
  logic [7:0] sw = 8'h00;
  logic press = 1'b0;
  logic [7:0] switch_w;
  logic reset_key_w, reset_in_w, gate_in_w, key_busy;
  twt_cfg_t key_cfg = '{RNG_HOURMIN, RNG_1MS, 1'b1, 1'b1, 1'b0};
  twt_cfg_t exp_cfg;
  logic twin = 1'b0, flick = 1'b0, edit = 1'b0;
  logic [15:0] cyc_t = 16'h0000, off_t = 16'h0000, on_t = 16'h0000;
  logic [6:0] duty = 7'h00;
  logic cpu_f = 1'b0, ram_f = 1'b0, nvm_f = 1'b0;
  logic out_w, restore_w;
  twt_disp_t disp_w;
  twt_cfg_t cfg_w;
  twt_fault_t fault_w;
  int fails = 0, tests_run = 0, restores = 0, n = 0, e = 0, d = 0, r0 = 0;

  twt_operator twt_operator_i (.core_clk_i(core_clk_i),
    .switch_set_i(sw_set), .press_i(press), .switch_o(switch_w),
    .reset_key_o(reset_key_w), .reset_in_o(reset_in_w),
    .gate_in_o(gate_in_w), .busy_o(key_busy));

  twt_timer_core #(.MS_TICK_CYCLES(TK)) twt_timer_core_i (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .switch_i(switch_w),
    .reset_in_i(reset_in_w), .gate_in_i(gate_in_w),
    .reset_key_i(reset_key_w), .key_cfg_i(key_cfg), .twin_mode_i(twin),
    .flicker_mode_i(flick), .edit_cycle_i(edit), .cycle_time_i(cyc_t),
    .cycle_range_i(RNG_10MS), .duty_i(duty), .off_time_i(off_t),
    .on_time_i(on_t), .cpu_fault_i(cpu_f), .ram_fault_i(ram_f),
    .nvm_fault_i(nvm_f), .out_o(out_w), .disp_o(disp_w), .cfg_o(cfg_w),
    .fault_o(fault_w), .factory_restore_o(restore_w));

  // clock and restore pulse tally
  always #5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    if (restore_w === 1'b1) begin
      restores <= restores + 1;
    end
  end

  // configuration expected from a switch bank value
  function automatic twt_cfg_t sw_cfg(input logic [7:0] s);
    sw_cfg.off_range = twt_range_t'({1'b0, s[2:1]});
    sw_cfg.on_range = twt_range_t'({1'b0, s[4:3]});
    sw_cfg.start_on = s[5];
    sw_cfg.count_down = s[6];
    sw_cfg.filt_fast = s[7];
  endfunction : sw_cfg

  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic cycles(input int k);
    repeat (k) @(negedge core_clk_i);
  endtask : cycles

  task automatic power_up(input logic [7:0] s);
    @(posedge core_clk_i);
    arst_n_i <= 1'b0;
    sw_set <= s;
    repeat (3) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    cycles(8);
  endtask : power_up

  task automatic press_key();
    @(posedge core_clk_i);
    press <= 1'b1;
    @(posedge core_clk_i);
    press <= 1'b0;
    cycles(1);
    while (key_busy) cycles(1);
    cycles(60);
  endtask : press_key

  // length in ticks of the next whole run of out_o at one level
  task automatic run_len(input logic lvl, output int len);
    len = 0;
    repeat (30000) if (out_w === lvl) cycles(1);
    repeat (30000) if (out_w !== lvl) cycles(1);
    repeat (30000) if (out_w === lvl) begin
      cycles(1);
      len++;
    end
    len = (len + TK / 2) / TK;
  endtask : run_len

  task automatic final_report();
    $display("checks %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report

  // watchdog
  initial begin
    cycles(90000);
    fails++;
    $display("unexpected run length: expected end, seen still running");
    final_report();
  end

  // main sequence
  initial begin
    void'($urandom(56596));
    power_up(8'h00);
    chk("out after reset", 0, out_w);
    chk("fault after reset", FLT_NONE, fault_w);
    chk("config with pins off", key_cfg, cfg_w);
    // switch bank capture and later changes ignored
    for (int i = 0; i < 8; i++) begin
      sw = 8'($urandom());
      sw[2:1] = 2'(i);
      sw[4:3] = ~2'(i);
      sw[0] = (i != 7);
      power_up(sw);
      exp_cfg = sw[0] ? sw_cfg(sw) : key_cfg;
      chk("switch config", exp_cfg, cfg_w);
      chk("ranges and modes", exp_cfg, cfg_w);
      @(posedge core_clk_i);
      sw_set <= ~sw;
      cycles(10);
      chk("config after change", exp_cfg, cfg_w);
    end
    power_up(8'h21);
    // flicker corner cases
    @(posedge core_clk_i);
    flick <= 1'b1;
    duty <= 7'h64;
    edit <= 1'b1;
    cycles(300);
    chk("out with zero cycle", 0, out_w);
    chk("sub while editing", SUB_CYCLE, disp_w.sub_sel);
    chk("cycle lamp", 1, disp_w.cycle_indicator);
    @(posedge core_clk_i);
    cyc_t <= 16'h000A;
    cycles(300);
    chk("out at full duty", 1, out_w);
    @(posedge core_clk_i);
    duty <= 7'h00;
    cycles(1200);
    chk("out at zero duty", 0, out_w);
    // flicker on time with rounding to 10 ms units
    for (int i = 0; i < 4; i++) begin
      d = $urandom_range(80, 20);
      @(posedge core_clk_i);
      duty <= 7'(d);
      run_len(1'b1, n);
      run_len(1'b1, n);
      e = ((10 * d + 50) / 100) * 10;
      chk("flicker on time", e, n);
    end
    // processor fault, cleared by the key
    @(posedge core_clk_i);
    duty <= 7'h64;
    edit <= 1'b0;
    cpu_f <= 1'b1;
    @(posedge core_clk_i);
    cpu_f <= 1'b0;
    cycles(5);
    chk("cpu fault out", 0, out_w);
    chk("cpu fault kind", FLT_CPU, fault_w);
    chk("cpu main", MAIN_PROCESSOR_FAULT_CODE, disp_w.main_sel);
    chk("cpu sub", SUB_DARK, disp_w.sub_sel);
    press_key();
    chk("cpu cleared", FLT_NONE, fault_w);
    chk("out after clear", 1, out_w);
    // working memory fault, key does not clear
    @(posedge core_clk_i);
    ram_f <= 1'b1;
    @(posedge core_clk_i);
    ram_f <= 1'b0;
    cycles(5);
    chk("ram main", MAIN_MEMORY_FAULT_CODE, disp_w.main_sel);
    chk("ram sub", SUB_DARK, disp_w.sub_sel);
    press_key();
    chk("ram kept", FLT_RAM, fault_w);
    chk("ram out", 0, out_w);
    power_up(8'h21);
    chk("ram after power", FLT_NONE, fault_w);
    // nonvolatile fault, key restores factory state
    @(posedge core_clk_i);
    nvm_f <= 1'b1;
    @(posedge core_clk_i);
    nvm_f <= 1'b0;
    cycles(5);
    chk("nvm main", MAIN_MEMORY_FAULT_CODE, disp_w.main_sel);
    chk("nvm sub", SUB_SUM, disp_w.sub_sel);
    chk("nvm out", 0, out_w);
    r0 = restores;
    press_key();
    chk("restore pulses", 1, restores - r0);
    chk("nvm cleared", FLT_NONE, fault_w);
    // twin operation from the on phase
    power_up(8'h21);
    @(posedge core_clk_i);
    flick <= 1'b0;
    twin <= 1'b1;
    off_t <= 16'h0003;
    on_t <= 16'h0002;
    cycles(5);
    chk("twin start phase", 1, out_w);
    run_len(1'b1, n);
    chk("twin on interval", 20, n);
    run_len(1'b0, n);
    chk("twin off interval", 30, n);
    chk("elapsed at start", 0, disp_w.pv);
    cycles(150);
    chk("elapsed units", 1, disp_w.pv);
    final_report();
  end
endmodule : tb
